// ==== eom_rx.sv ====
// receive-side e1 crc4 multiframe overhead monitor and substitution block
// ------------------------------------------------------------
// Summary of operation
// - crc4 mismatch count register refreshes twice every multiframe.
// - counter advances by one on each received versus computed crc4 mismatch.
// - counter wraps from 255 to zero.
// - counter cleared or counting according to clear bit in control register two.
// - clear bit 0 counts normally, 1 holds counter at zero.
// - in-band code field updates only after 8 identical submultiframes.
// - a masked in-band code field is not updated.
// - code register holds a in bit 0, sa5 bit 1, sa6 nibble bits 4-7.
// - status bit 0 and 1 report crc result of submultiframes 1 and 2.
// - sa4, sa7, sa8 status take the value seen 5 or more times.
// - status bit 7 reads 1 while multiframe sync is achieved.
// - offset register low nibble holds frame number where sync was achieved.
// - sa4, sa7, sa8 toward pcm pass through or come from bits buffer 1.
// - sa5, sa6 toward pcm pass through or come from bits buffer 0.
// - e-bit mode 00 pass, 01 buffer 0, 10 automatic, 11 illegal.
// - automatic e-bit is 0 on failed crc4 check, 1 on pass.
// - source select write applies from the next multiframe boundary.
// ------------------------------------------------------------
`timescale 1ns/100ps
module eom_rx (
  input  wire logic             clk,        // 125 mhz clock
  input  wire logic             rst_b,      // synchronous reset, active low
  input  wire logic [7:0]       mpu_addr,   // register address
  input  wire logic             mpu_wr,     // write strobe, one cycle
  input  wire logic             mpu_rd,     // read strobe, one cycle
  input  wire logic [7:0]       mpu_wdata,  // write data
  output logic      [7:0]       mpu_rdata,  // read data, one cycle after strobe
  input  wire eom_pkg::eom_ts0_t rx_ts0,    // received slot 0 byte and frame number
  input  wire eom_pkg::eom_crc_t rx_crc,    // per-submultiframe crc4 comparison
  input  wire logic             sync_locked, // multiframe sync machine locked
  input  wire logic [3:0]       sync_frame, // relative frame at which lock came
  output eom_pkg::eom_ts0_t     pcm_ts0,    // slot 0 byte sent toward pcm
  output logic      [1:0]       hdsl_e_bits // e2:e1 sent toward hdsl
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  eom_pkg::eom_st_t s_q;
  eom_pkg::eom_st_t s_d;

  // counts how many submultiframes in a row one in-band field has kept its value
  function automatic logic [3:0] run_next(input logic same, input logic [3:0] run);
    if (!same) begin
      run_next = 4'h1;
    end else if (run == eom_pkg::RUN_FULL) begin
      run_next = run;
    end else begin
      run_next = run + 4'h1;
    end
  endfunction : run_next

  // majority of eight samples; a 4/4 tie keeps the old value
  function automatic logic maj(input logic [3:0] ones, input logic old);
    if (ones >= eom_pkg::MAJ_MIN) begin
      maj = 1'b1;
    end else if (ones <= (4'h8 - eom_pkg::MAJ_MIN)) begin
      maj = 1'b0;
    end else begin
      maj = old;
    end
  endfunction : maj

  logic       nfas;
  logic       mf_start;
  logic       sub_end;
  logic [1:0] slot;
  logic [7:0] sub_bits;
  logic [1:0] e_mode;
  logic [7:0] byte_out;

  assign nfas     = rx_ts0.valid & rx_ts0.frame[0];
  assign mf_start = rx_ts0.valid & (rx_ts0.frame == 4'h0);
  assign sub_end  = nfas & ((rx_ts0.frame == eom_pkg::FRM_SUB1) |
                            (rx_ts0.frame == eom_pkg::FRM_LAST));
  assign slot     = rx_ts0.frame[2:1];
  assign e_mode   = s_q.sel_act[eom_pkg::SEL_E_LO +: 2];

  always_comb begin
    s_d       = s_q;
    sub_bits  = 8'h00;
    byte_out  = rx_ts0.ts0;
    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    if (mpu_wr) begin
      unique case (mpu_addr)
        eom_pkg::OFS_SRC_SEL:  s_d.sel_wr   = mpu_wdata & eom_pkg::SEL_WMASK;
        eom_pkg::OFS_CTRL2:    s_d.ctrl2_wr = mpu_wdata;
        eom_pkg::OFS_BUF_ONE:  s_d.buf1     = mpu_wdata & 8'h77;
        eom_pkg::OFS_BUF_ZERO: s_d.buf0     = mpu_wdata;
        default: ;
      endcase
    end
    // reads return stored values only, nothing is cleared on read
    if (mpu_rd) begin
      unique case (mpu_addr)
        eom_pkg::OFS_CRC_CNT:  s_d.rdata = s_q.cnt;
        eom_pkg::OFS_CODE:     s_d.rdata = s_q.code;
        eom_pkg::OFS_STATUS:   s_d.rdata = {s_q.synced, s_q.sa_maj, 2'b00, s_q.crc_fail};
        eom_pkg::OFS_OFFSET:   s_d.rdata = {4'h0, s_q.offset};
        eom_pkg::OFS_SRC_SEL:  s_d.rdata = s_q.sel_wr;
        eom_pkg::OFS_CTRL2:    s_d.rdata = s_q.ctrl2_wr;
        eom_pkg::OFS_BUF_ONE:  s_d.rdata = s_q.buf1;
        eom_pkg::OFS_BUF_ZERO: s_d.rdata = s_q.buf0;
        default:               s_d.rdata = 8'h00;
      endcase
    end
    // ------------------------------------------------------------
    // multiframe boundary: control takes effect here
    // ------------------------------------------------------------
    if (mf_start) begin
      s_d.sel_act = s_q.sel_wr;
      s_d.clr_act = s_q.ctrl2_wr[eom_pkg::CTRL2_CRC_CLR];
    end
    // ------------------------------------------------------------
    // crc4 mismatch counter and per-submultiframe result
    // ------------------------------------------------------------
    if (s_q.clr_act) begin
      s_d.cnt = 8'h00;
    end else if (rx_crc.valid && (rx_crc.rx != rx_crc.calc)) begin
      s_d.cnt = s_q.cnt + 8'h01;
    end
    if (rx_crc.valid) begin
      s_d.crc_fail[rx_crc.second] = (rx_crc.rx != rx_crc.calc);
    end
    // ------------------------------------------------------------
    // sync status; offset is caught on the lock edge
    // ------------------------------------------------------------
    s_d.synced = sync_locked;
    if (sync_locked && !s_q.synced) begin
      s_d.offset = sync_frame;
    end
    // ------------------------------------------------------------
    // spare bit capture on odd (non-alignment) frames
    // ------------------------------------------------------------
    if (nfas) begin
      s_d.ones4 = s_q.ones4 + {3'b000, rx_ts0.ts0[eom_pkg::TS0_SA4]};
      s_d.ones7 = s_q.ones7 + {3'b000, rx_ts0.ts0[eom_pkg::TS0_SA7]};
      s_d.ones8 = s_q.ones8 + {3'b000, rx_ts0.ts0[eom_pkg::TS0_SA8]};
      s_d.a_acc = rx_ts0.ts0[eom_pkg::TS0_A];
      s_d.s5_acc = rx_ts0.ts0[eom_pkg::TS0_SA5];
      s_d.s6_acc[slot] = rx_ts0.ts0[eom_pkg::TS0_SA6];
      if (rx_ts0.frame == eom_pkg::FRM_E1) begin
        s_d.e_rx[0] = rx_ts0.ts0[eom_pkg::TS0_SI];
      end
      if (rx_ts0.frame == eom_pkg::FRM_LAST) begin
        s_d.e_rx[1] = rx_ts0.ts0[eom_pkg::TS0_SI];
      end
    end
    if (sub_end) begin
      sub_bits = {s_d.s6_acc, 2'b00, s_d.s5_acc, s_d.a_acc};
      s_d.a_run   = run_next(sub_bits[0] == s_q.a_cand, s_q.a_run);
      s_d.s5_run  = run_next(sub_bits[1] == s_q.s5_cand, s_q.s5_run);
      s_d.s6_run  = run_next(sub_bits[7:4] == s_q.s6_cand, s_q.s6_run);
      s_d.a_cand  = sub_bits[0];
      s_d.s5_cand = sub_bits[1];
      s_d.s6_cand = sub_bits[7:4];
      if (s_d.a_run == eom_pkg::RUN_FULL && !s_q.buf1[eom_pkg::BUF1_MASK_A]) begin
        s_d.code[0] = sub_bits[0];
      end
      if (s_d.s5_run == eom_pkg::RUN_FULL && !s_q.buf1[eom_pkg::BUF1_MASK_SA5]) begin
        s_d.code[1] = sub_bits[1];
      end
      if (s_d.s6_run == eom_pkg::RUN_FULL && !s_q.buf1[eom_pkg::BUF1_MASK_SA6]) begin
        s_d.code[7:4] = sub_bits[7:4];
      end
    end
    // majority over the eight odd frames of the multiframe
    if (nfas && rx_ts0.frame == eom_pkg::FRM_LAST) begin
      s_d.sa_maj[0] = maj(s_d.ones4, s_q.sa_maj[0]);
      s_d.sa_maj[1] = maj(s_d.ones7, s_q.sa_maj[1]);
      s_d.sa_maj[2] = maj(s_d.ones8, s_q.sa_maj[2]);
      s_d.ones4 = 4'h0;
      s_d.ones7 = 4'h0;
      s_d.ones8 = 4'h0;
      // e-bits toward hdsl refresh once per multiframe
      unique case (e_mode)
        eom_pkg::E_PASS: s_d.e_out = s_d.e_rx;
        eom_pkg::E_BUF:  s_d.e_out = s_q.buf0[eom_pkg::BUF0_E_LO +: 2];
        eom_pkg::E_AUTO: s_d.e_out = ~s_d.crc_fail;
        default:         s_d.e_out = s_q.e_out;
      endcase
    end
    // ------------------------------------------------------------
    // slot 0 toward pcm with spare bit substitution
    // ------------------------------------------------------------
    if (nfas) begin
      if (s_q.sel_act[eom_pkg::SEL_SA4]) begin
        byte_out[eom_pkg::TS0_SA4] = s_q.buf1[eom_pkg::BUF1_SA4];
      end
      if (s_q.sel_act[eom_pkg::SEL_SA7]) begin
        byte_out[eom_pkg::TS0_SA7] = s_q.buf1[eom_pkg::BUF1_SA7];
      end
      if (s_q.sel_act[eom_pkg::SEL_SA8]) begin
        byte_out[eom_pkg::TS0_SA8] = s_q.buf1[eom_pkg::BUF1_SA8];
      end
      if (s_q.sel_act[eom_pkg::SEL_SA5]) begin
        byte_out[eom_pkg::TS0_SA5] = s_q.buf0[eom_pkg::BUF0_SA5];
      end
      if (s_q.sel_act[eom_pkg::SEL_SA6]) begin
        byte_out[eom_pkg::TS0_SA6] = s_q.buf0[eom_pkg::BUF0_SA6_LO + slot];
      end
    end
    s_d.out_valid = rx_ts0.valid;
    if (rx_ts0.valid) begin
      s_d.out_ts0 = byte_out;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign mpu_rdata     = s_q.rdata;
  assign pcm_ts0.valid = s_q.out_valid;
  assign pcm_ts0.frame = 4'h0;
  assign pcm_ts0.ts0   = s_q.out_ts0;
  assign hdsl_e_bits   = s_q.e_out;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic mism;
  assign mism = rx_crc.valid && (rx_crc.rx != rx_crc.calc);
  // frame 15 slot 0 closes the multiframe: majority and e-bits settle here
  logic       mf_last;
  logic [3:0] ones4_now;
  assign mf_last   = nfas & (rx_ts0.frame == eom_pkg::FRM_LAST);
  assign ones4_now = s_q.ones4 + {3'b000, rx_ts0.ts0[eom_pkg::TS0_SA4]};

  cnt_advance_a: assert property (@(posedge clk) disable iff (!rst_b)
    mism && !s_q.clr_act |=> s_q.cnt == $past(s_q.cnt) + 8'h01)
    else $error("crc mismatch count did not advance by one");
  cnt_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    !mism && !s_q.clr_act |=> s_q.cnt == $past(s_q.cnt))
    else $error("crc mismatch count moved without a mismatch");
  cnt_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    s_q.clr_act |=> s_q.cnt == 8'h00)
    else $error("crc mismatch count not held clear");
  crc_result_a: assert property (@(posedge clk) disable iff (!rst_b)
    rx_crc.valid && !rx_crc.second |=> s_q.crc_fail[0] == $past(mism))
    else $error("submultiframe one crc result wrong");
  sync_bit_a: assert property (@(posedge clk) disable iff (!rst_b)
    sync_locked ##1 sync_locked |=> s_q.synced)
    else $error("synced status not reported");
  offset_catch_a: assert property (@(posedge clk) disable iff (!rst_b)
    sync_locked && !s_q.synced |=> s_q.offset == $past(sync_frame))
    else $error("sync offset not captured at lock");
  sel_boundary_a: assert property (@(posedge clk) disable iff (!rst_b)
    !mf_start |=> s_q.sel_act == $past(s_q.sel_act))
    else $error("source select changed away from a boundary");
  auto_ebit_a: assert property (@(posedge clk) disable iff (!rst_b)
    nfas && rx_ts0.frame == eom_pkg::FRM_LAST && e_mode == eom_pkg::E_AUTO && !rx_crc.valid
    |=> s_q.e_out == ~s_q.crc_fail)
    else $error("automatic e-bits do not follow crc result");
  sa4_pass_a: assert property (@(posedge clk) disable iff (!rst_b)
    nfas && !s_q.sel_act[eom_pkg::SEL_SA4]
    |=> s_q.out_ts0[eom_pkg::TS0_SA4] == $past(rx_ts0.ts0[eom_pkg::TS0_SA4]))
    else $error("sa4 not passed through");
  read_quiet_a: assert property (@(posedge clk) disable iff (!rst_b)
    mpu_rd && !mpu_wr && !rx_crc.valid && !rx_ts0.valid && !s_q.clr_act
    |=> s_q.cnt == $past(s_q.cnt) && s_q.code == $past(s_q.code))
    else $error("register read disturbed state");
  cnt_wrap_a: assert property (@(posedge clk) disable iff (!rst_b)
    mism && !s_q.clr_act && (&s_q.cnt) |=> s_q.cnt == 8'h00)
    else $error("crc mismatch count did not wrap to zero");
  clr_arm_a: assert property (@(posedge clk) disable iff (!rst_b)
    mf_start |=> s_q.clr_act == $past(s_q.ctrl2_wr[eom_pkg::CTRL2_CRC_CLR]))
    else $error("counter clear bit not taken at the boundary");
  crc_second_a: assert property (@(posedge clk) disable iff (!rst_b)
    rx_crc.valid && rx_crc.second |=> s_q.crc_fail[1] == $past(mism))
    else $error("submultiframe two crc result wrong");
  sync_off_a: assert property (@(posedge clk) disable iff (!rst_b)
    !sync_locked |=> !s_q.synced)
    else $error("synced status reported without lock");
  code_only_a: assert property (@(posedge clk) disable iff (!rst_b)
    !sub_end |=> $stable(s_q.code))
    else $error("in-band code moved away from a submultiframe end");
  code_fresh_a: assert property (@(posedge clk) disable iff (!rst_b)
    sub_end && rx_ts0.ts0[eom_pkg::TS0_A] != s_q.a_cand |=> $stable(s_q.code[0]))
    else $error("a freshly changed a bit was adopted");
  code_mask_a: assert property (@(posedge clk) disable iff (!rst_b)
    sub_end && s_q.buf1[eom_pkg::BUF1_MASK_A] |=> $stable(s_q.code[0]))
    else $error("masked a bit field was updated");
  code_adopt_a: assert property (@(posedge clk) disable iff (!rst_b)
    sub_end && s_q.a_run == eom_pkg::RUN_FULL && !s_q.buf1[eom_pkg::BUF1_MASK_A] &&
    rx_ts0.ts0[eom_pkg::TS0_A] == s_q.a_cand
    |=> s_q.code[0] == $past(rx_ts0.ts0[eom_pkg::TS0_A]))
    else $error("persistent a bit not placed in code bit 0");
  maj_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    !mf_last |=> $stable(s_q.sa_maj))
    else $error("spare majority moved away from frame 15");
  maj_one_a: assert property (@(posedge clk) disable iff (!rst_b)
    mf_last && ones4_now >= eom_pkg::MAJ_MIN |=> s_q.sa_maj[0])
    else $error("sa4 majority of ones not reported");
  maj_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
    mf_last && ones4_now + eom_pkg::MAJ_MIN <= 4'h8 |=> !s_q.sa_maj[0])
    else $error("sa4 majority of zeros not reported");
  sa5_sub_a: assert property (@(posedge clk) disable iff (!rst_b)
    nfas && s_q.sel_act[eom_pkg::SEL_SA5]
    |=> s_q.out_ts0[eom_pkg::TS0_SA5] == $past(s_q.buf0[eom_pkg::BUF0_SA5]))
    else $error("sa5 not taken from buffer zero");
  sa6_sub_a: assert property (@(posedge clk) disable iff (!rst_b)
    nfas && s_q.sel_act[eom_pkg::SEL_SA6]
    |=> s_q.out_ts0[eom_pkg::TS0_SA6] == $past(s_q.buf0[eom_pkg::BUF0_SA6_LO + slot]))
    else $error("sa6 not taken from buffer zero");
  sa7_sub_a: assert property (@(posedge clk) disable iff (!rst_b)
    nfas && s_q.sel_act[eom_pkg::SEL_SA7]
    |=> s_q.out_ts0[eom_pkg::TS0_SA7] == $past(s_q.buf1[eom_pkg::BUF1_SA7]))
    else $error("sa7 not taken from buffer one");
  sa8_sub_a: assert property (@(posedge clk) disable iff (!rst_b)
    nfas && s_q.sel_act[eom_pkg::SEL_SA8]
    |=> s_q.out_ts0[eom_pkg::TS0_SA8] == $past(s_q.buf1[eom_pkg::BUF1_SA8]))
    else $error("sa8 not taken from buffer one");
  even_pass_a: assert property (@(posedge clk) disable iff (!rst_b)
    rx_ts0.valid && !nfas |=> s_q.out_ts0 == $past(rx_ts0.ts0))
    else $error("alignment frame byte altered");
  ebuf_mode_a: assert property (@(posedge clk) disable iff (!rst_b)
    mf_last && e_mode == eom_pkg::E_BUF
    |=> s_q.e_out == $past(s_q.buf0[eom_pkg::BUF0_E_LO +: 2]))
    else $error("e-bits not taken from buffer zero");
  epass_mode_a: assert property (@(posedge clk) disable iff (!rst_b)
    mf_last && e_mode == eom_pkg::E_PASS
    |=> s_q.e_out == {$past(rx_ts0.ts0[eom_pkg::TS0_SI]), $past(s_q.e_rx[0])})
    else $error("e-bits not passed through");
  eill_mode_a: assert property (@(posedge clk) disable iff (!rst_b)
    mf_last && (&e_mode) |=> $stable(s_q.e_out))
    else $error("illegal e-bit mode changed the e-bits");

  cnt_wrap_c: cover property (@(posedge clk) disable iff (!rst_b)
    s_q.cnt == 8'hff ##1 s_q.cnt == 8'h00);
  code_upd_c: cover property (@(posedge clk) disable iff (!rst_b)
    s_q.code != $past(s_q.code));
  auto_mode_c: cover property (@(posedge clk) disable iff (!rst_b)
    mf_start && s_q.sel_wr[eom_pkg::SEL_E_LO +: 2] == eom_pkg::E_AUTO);
  lock_c: cover property (@(posedge clk) disable iff (!rst_b)
    !s_q.synced ##1 s_q.synced);
endmodule : eom_rx

// ==== eom_pkg.sv ====
// shared constants and carrier types for the e1 multiframe overhead receive block
package eom_pkg;
  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CRC_CNT   = 8'h84;
  localparam logic [7:0] OFS_CODE      = 8'h85;
  localparam logic [7:0] OFS_STATUS    = 8'h86;
  localparam logic [7:0] OFS_OFFSET    = 8'h87;
  localparam logic [7:0] OFS_SRC_SEL   = 8'hb0;
  localparam logic [7:0] OFS_CTRL2     = 8'hb1;
  localparam logic [7:0] OFS_BUF_ONE   = 8'hb2;
  localparam logic [7:0] OFS_BUF_ZERO  = 8'hb4;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int SEL_SA4 = 0;
  localparam int SEL_SA5 = 1;
  localparam int SEL_SA6 = 2;
  localparam int SEL_UNUSED = 3;
  localparam int SEL_SA7 = 4;
  localparam int SEL_SA8 = 5;
  localparam int SEL_E_LO = 6;
  localparam int CTRL2_CRC_CLR = 7;
  localparam int BUF1_SA4 = 0;
  localparam int BUF1_SA7 = 1;
  localparam int BUF1_SA8 = 2;
  localparam int BUF1_MASK_A = 4;
  localparam int BUF1_MASK_SA5 = 5;
  localparam int BUF1_MASK_SA6 = 6;
  localparam int BUF0_E_LO = 0;
  localparam int BUF0_SA5 = 2;
  localparam int BUF0_SA6_LO = 4;
  localparam int TS0_SI = 7;
  localparam int TS0_A = 5;
  localparam int TS0_SA4 = 4;
  localparam int TS0_SA5 = 3;
  localparam int TS0_SA6 = 2;
  localparam int TS0_SA7 = 1;
  localparam int TS0_SA8 = 0;
  // ------------------------------------------------------------
  // reset values and counts
  // ------------------------------------------------------------
  localparam logic [7:0] RST_REG   = 8'h00;
  localparam logic [7:0] SEL_WMASK = 8'hf7;
  localparam logic [3:0] RUN_FULL  = 4'h8;
  localparam logic [3:0] MAJ_MIN   = 4'h5;
  localparam logic [3:0] FRM_E1    = 4'hd;
  localparam logic [3:0] FRM_SUB1  = 4'h7;
  localparam logic [3:0] FRM_LAST  = 4'hf;
  localparam logic [1:0] E_PASS    = 2'h0;
  localparam logic [1:0] E_BUF     = 2'h1;
  localparam logic [1:0] E_AUTO    = 2'h2;
  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic [3:0] frame;
    logic [7:0] ts0;
  } eom_ts0_t;
  typedef struct packed {
    logic       valid;
    logic       second;
    logic [3:0] rx;
    logic [3:0] calc;
  } eom_crc_t;
  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] code;
    logic [1:0] crc_fail;
    logic [2:0] sa_maj;
    logic       synced;
    logic [3:0] offset;
    logic [7:0] sel_wr;
    logic [7:0] sel_act;
    logic [7:0] ctrl2_wr;
    logic       clr_act;
    logic [7:0] buf1;
    logic [7:0] buf0;
    logic [3:0] ones4;
    logic [3:0] ones7;
    logic [3:0] ones8;
    logic       a_acc;
    logic       s5_acc;
    logic [3:0] s6_acc;
    logic       a_cand;
    logic [3:0] a_run;
    logic       s5_cand;
    logic [3:0] s5_run;
    logic [3:0] s6_cand;
    logic [3:0] s6_run;
    logic [1:0] e_rx;
    logic       out_valid;
    logic [7:0] out_ts0;
    logic [1:0] e_out;
    logic [7:0] rdata;
  } eom_st_t;
endpackage : eom_pkg

// ==== eom_frame_src.sv ====
// pcm-side framer model feeding slot 0 bytes and crc4 results to the block
`timescale 1ns/100ps
module eom_frame_src (
  input  wire logic         clk,    // bench clock
  input  wire logic         rst_b,  // synchronous reset, active low
  input  wire logic [7:0]   spare,  // slot 0 byte sent in odd frames
  input  wire logic [7:0]   flip,   // per odd frame, invert sa4, sa7 and sa8
  input  wire logic [1:0]   bad,    // force a crc4 mismatch per submultiframe
  output eom_pkg::eom_ts0_t rx_ts0, // one slot 0 byte every four cycles
  output eom_pkg::eom_crc_t rx_crc  // one crc4 comparison per submultiframe
);
  // ------------------------------------------------------------
  // frame sequencing
  // ------------------------------------------------------------
  logic [1:0] cyc_q;
  logic [3:0] frm_q;
  logic       run_q;
  initial begin
    rx_ts0 = '0;
    rx_crc = '0;
  end
  // reset seen on the rising edge so the falling-edge driver never races it
  always @(posedge clk) run_q <= rst_b;
  always @(negedge clk) begin
    rx_ts0.valid <= 1'b0;
    rx_ts0.ts0   <= ~rx_ts0.ts0;
    rx_crc.valid <= 1'b0;
    rx_crc.calc  <= ~rx_crc.calc;
    if (!run_q) begin
      cyc_q <= 2'h0;
      frm_q <= 4'h0;
    end else begin
      cyc_q <= cyc_q + 2'h1;
      if (cyc_q == 2'h0) begin
        rx_ts0.valid <= 1'b1;
        rx_ts0.frame <= frm_q;
        rx_ts0.ts0   <= frm_q[0] ? spare ^ (flip[frm_q[3:1]] ? 8'h13 : 8'h00) : {spare[7], 7'h1b};
      end
      if (cyc_q == 2'h3) frm_q <= frm_q + 4'h1;
      // crc result arrives before slot 0 of frames 7 and 15
      if (cyc_q == 2'h2 && frm_q[2:0] == 3'h6) begin
        rx_crc.valid  <= 1'b1;
        rx_crc.second <= frm_q[3];
        rx_crc.rx     <= 4'ha;
        rx_crc.calc   <= bad[frm_q[3]] ? 4'h5 : 4'ha;
      end
    end
  end
endmodule : eom_frame_src

// ==== e1_multiframe_overhead_rx_bench.sv ====
// self-checking bench for the e1 multiframe overhead receive block
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module e1_multiframe_overhead_rx_bench;
  logic              clk;
  logic              rst_b;
  logic [7:0]        mpu_addr;
  logic              mpu_wr;
  logic              mpu_rd;
  logic [7:0]        mpu_wdata;
  logic [7:0]        mpu_rdata;
  eom_pkg::eom_ts0_t rx_ts0;
  eom_pkg::eom_crc_t rx_crc;
  logic              sync_locked;
  logic [3:0]        sync_frame;
  eom_pkg::eom_ts0_t pcm_ts0;
  logic [1:0]        hdsl_e_bits;
  logic [7:0]        spare;
  logic [7:0]        flip;
  logic [1:0]        bad;
  logic [7:0]        rv;
  logic [7:0]        c0;
  logic [3:0]        f_q;
  logic [7:0]        got [16];
  int                fails;
  int                n_compared;
  int                cycles;
  eom_rx i_dut (
    .clk(clk), .rst_b(rst_b), .mpu_addr(mpu_addr), .mpu_wr(mpu_wr), .mpu_rd(mpu_rd),
    .mpu_wdata(mpu_wdata), .mpu_rdata(mpu_rdata), .rx_ts0(rx_ts0), .rx_crc(rx_crc),
    .sync_locked(sync_locked), .sync_frame(sync_frame), .pcm_ts0(pcm_ts0),
    .hdsl_e_bits(hdsl_e_bits)
  );
  eom_frame_src i_src (
    .clk(clk), .rst_b(rst_b), .spare(spare), .flip(flip), .bad(bad),
    .rx_ts0(rx_ts0), .rx_crc(rx_crc)
  );
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // pcm bytes filed by the frame number they came in with
  always @(posedge clk) begin
    if (rx_ts0.valid) f_q <= rx_ts0.frame;
    if (pcm_ts0.valid) got[f_q] <= pcm_ts0.ts0;
  end
  // whole run needs about 11000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      test_done();
    end
  end
  // ------------------------------------------------------------
  // bus and timing helpers
  // ------------------------------------------------------------
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    mpu_addr  = a;
    mpu_wdata = d;
    mpu_wr    = 1'b1;
    @(negedge clk);
    mpu_wr    = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    mpu_addr = a;
    mpu_rd   = 1'b1;
    @(negedge clk);
    mpu_rd   = 1'b0;
    rv       = mpu_rdata;
  endtask : rd
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    `CHK(rv, e)
  endtask : rdchk
  task automatic wait_frame(input logic [3:0] f);
    @(posedge clk iff (rx_ts0.valid === 1'b1 && rx_ts0.frame === f));
  endtask : wait_frame
  // returns on a falling edge just before slot 0 of the next frame 0
  task automatic wait_mf(input int n);
    repeat (n) wait_frame(4'hf);
    repeat (2) @(negedge clk);
  endtask : wait_mf
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    logic [7:0] ofs [9] = '{8'h84, 8'h85, 8'h86, 8'h87, 8'hb0, 8'hb1, 8'hb2, 8'hb4, 8'h88};
    foreach (ofs[i]) rdchk(ofs[i], 8'h00);
    wr(8'h84, 8'hff);
    rdchk(8'h84, 8'h00);
    wr(8'hb2, 8'hff);
    rdchk(8'hb2, 8'h77);
    wr(8'hb2, 8'h00);
  endtask : t_regs
  task automatic t_counter;
    bad = 2'b11;
    wait_mf(1);
    rd(8'h84);
    c0 = rv;
    wait_mf(1);
    rdchk(8'h84, c0 + 8'h02);
    rdchk(8'h84, c0 + 8'h02);
    rd(8'h86);
    `CHK(rv[1:0], 2'b11)
    bad = 2'b01;
    wait_mf(1);
    rdchk(8'h84, c0 + 8'h03);
    rd(8'h86);
    `CHK(rv[1:0], 2'b01)
    wr(8'hb1, 8'h80);
    bad = 2'b11;
    wait_mf(2);
    rdchk(8'h84, 8'h00);
    rdchk(8'hb1, 8'h80);
    wr(8'hb1, 8'h00);
    wait_mf(1);
    rd(8'h84);
    c0 = rv;
    wait_mf(128);
    rdchk(8'h84, c0);
    wait_mf(1);
    rdchk(8'h84, c0 + 8'h02);
    bad = 2'b00;
  endtask : t_counter
  task automatic t_sync;
    sync_frame = 4'h9;
    @(negedge clk);
    sync_locked = 1'b1;
    repeat (3) @(negedge clk);
    sync_frame = 4'h3;
    rd(8'h86);
    `CHK(rv[7], 1'b1)
    if (rv[7] === 1'b1) rdchk(8'h87, 8'h09);
    sync_locked = 1'b0;
    rd(8'h86);
    `CHK(rv[7], 1'b0)
  endtask : t_sync
  task automatic t_code;
    wait_mf(1);
    spare = 8'h2c;
    wait_mf(3);
    rdchk(8'h85, 8'h00);
    wait_mf(1);
    rdchk(8'h85, 8'hf3);
    wr(8'hb2, 8'h10);
    spare = 8'h04;
    wait_mf(5);
    rdchk(8'h85, 8'hf1);
    wr(8'hb2, 8'h00);
    wait_mf(5);
    rdchk(8'h85, 8'hf0);
  endtask : t_code
  task automatic t_major;
    logic [7:0] fl [3] = '{8'h1f, 8'h0f, 8'h07};
    logic [2:0] ex [3] = '{3'h7, 3'h7, 3'h0};
    spare = 8'h00;
    wait_mf(1);
    for (int i = 0; i < 3; i++) begin
      flip = fl[i];
      wait_mf(1);
      rd(8'h86);
      `CHK(rv[6:4], ex[i])
    end
    flip = 8'h00;
  endtask : t_major
  task automatic t_subst;
    wr(8'hb2, 8'h05);
    wr(8'hb4, 8'ha4);
    wait_mf(1);
    wait_frame(4'h3);
    wr(8'hb0, 8'h37);
    wait_frame(4'h9);
    `CHK(got[5], 8'h00)
    wait_mf(1);
    wait_frame(4'hd);
    `CHK(got[1], 8'h19)
    `CHK(got[11], 8'h1d)
  endtask : t_subst
  task automatic t_ebits;
    logic [7:0] sel [5] = '{8'h00, 8'h40, 8'h80, 8'h80, 8'hc0};
    logic [1:0] err [5] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h2};
    logic [1:0] ex [5] = '{2'h3, 2'h1, 2'h2, 2'h1, 2'h1};
    spare = 8'h80;
    wr(8'hb4, 8'h01);
    wait_mf(1);
    for (int i = 0; i < 5; i++) begin
      bad = err[i];
      wr(8'hb0, sel[i]);
      wait_mf(2);
      `CHK(hdsl_e_bits, ex[i])
    end
  endtask : t_ebits
  initial begin
    fails = 0;
    n_compared = 0;
    cycles = 0;
    rst_b = 1'b0;
    mpu_addr = 8'h00;
    mpu_wr = 1'b0;
    mpu_rd = 1'b0;
    mpu_wdata = 8'h00;
    sync_locked = 1'b0;
    sync_frame = 4'h0;
    spare = 8'h00;
    flip = 8'h00;
    bad = 2'b00;
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    t_regs();
    t_counter();
    t_sync();
    t_code();
    t_major();
    t_subst();
    t_ebits();
    test_done();
  end
endmodule : e1_multiframe_overhead_rx_bench
